// >>> pkg/dwsr_pkg.sv
// Shared constants and carriers for the DRAM command-timing model.
// Assumes a single 50 MHz clock domain; used by rtl/ files.
package dwsr_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] DWSR_OFS_MODE = 8'h00;
  localparam logic [7:0] DWSR_OFS_STATUS = 8'h04;
  localparam logic [7:0] DWSR_OFS_BANKS = 8'h08;
  localparam logic [7:0] DWSR_OFS_LAT = 8'h0c;
  localparam logic [7:0] DWSR_OFS_WBEATS = 8'h10;
  // Mode register fields
  localparam int DWSR_MODE_BL_LSB = 0;
  localparam int DWSR_MODE_AL_LSB = 4;
  localparam int DWSR_MODE_CWL_LSB = 8;
  localparam logic [1:0] DWSR_BL_FIXED8 = 2'h0;
  localparam logic [1:0] DWSR_BL_OTF = 2'h1;
  localparam logic [1:0] DWSR_BL_FIXED4 = 2'h2;
  localparam logic [31:0] DWSR_MODE_RST = 32'h0000_0500;
  // Burst lengths in beats
  localparam logic [3:0] DWSR_BEATS_BL8 = 4'h8;
  localparam logic [3:0] DWSR_BEATS_BC4 = 4'h4;
  // Internal refresh must start within the minimum CKE pulse time
  localparam int DWSR_TCKE_NS = 5;
  localparam int DWSR_CLK_NS = 20;
  localparam int DWSR_TCKE_CYC = (DWSR_TCKE_NS / DWSR_CLK_NS) < 1 ? 1
                                 : DWSR_TCKE_NS / DWSR_CLK_NS;
  // DLL relock time after self refresh exit, in clocks
  localparam logic [9:0] DWSR_DLL_LOCK_CYC = 10'h200;
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    DWSR_CMD_MRS = 4'h0,
    DWSR_CMD_REF = 4'h1,
    DWSR_CMD_PRE = 4'h2,
    DWSR_CMD_ACT = 4'h3,
    DWSR_CMD_WR = 4'h4,
    DWSR_CMD_RD = 4'h5,
    DWSR_CMD_ZQ = 4'h6,
    DWSR_CMD_NOP = 4'h7
  } dwsr_cmd_t;
  // Command bus from the controller
  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [15:0] addr;
  } dwsr_cmdbus_t;
  // Self refresh states
  typedef enum logic [1:0] {
    DWSR_ST_NORM = 2'b00,
    DWSR_ST_SREF = 2'b01,
    DWSR_ST_RELK = 2'b10
  } dwsr_st_t;
endpackage

// >>> rtl/dwsr_bank_mem.sv
`timescale 1ns/1ps
// Small register memory of open-row addresses, one word per bank.
// Assumes one clock; read data registered one cycle after address.
module dwsr_bank_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  // Plain write, registered read; no reset so it maps to RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// >>> rtl/dwsr_core.sv
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// DRAM device-side command model: burst length, write capture, precharge,
// self refresh with DLL handling; Wishbone slave for mode and status.
// Assumes command pins come from another domain and are synchronised here.
// How it works
// [RULE1] Controller starts write-to-read count after last data, fixed chop.
// [RULE2] Controller starts write-to-read count after full burst time, on-the-fly chop.
// [RULE3] Burst field 10 makes every read and write a four-beat chop; the code decodes it for writes only.
// [RULE4] Burst field 01 with A12 low gives a four-beat chop.
// [RULE5] Controller waits write recovery before precharging the written bank.
// [RULE6] Controller drives strobe high then low half clock as write preamble.
// [RULE7] Controller holds strobe low after last data as write postamble.
// [RULE8] Precharge: A10 high closes all banks, else only bank BA.
// [RULE9] Precharged bank goes idle; read or write needs activate first.
// [RULE10] Refresh registered with clock enable low enters self refresh.
// [RULE11] DLL off entering self refresh, re-enabled and reset on exit.
// [RULE12] Controller waits 512 clocks after data reference valid before writing.
// [RULE13] Self refresh only with all banks precharged and no burst.
// [RULE14] Controller drives termination low before self refresh entry.
// [RULE15] Clock enable low keeps self refresh; other inputs ignored meanwhile.
// [RULE16] One internal refresh within minimum clock-enable pulse after entry.
// [RULE17] Controller keeps clock stable and honours minimum residency.
// [RULE18] Controller honours clock hold times if clock stopped or changed.
// [RULE19] Controller issues only no-ops for exit time after leaving.
// [RULE20] Controller calibrates and waits DLL time before DLL commands.
// [RULE21] Controller issues a no-op right after the entry command.
// [RULE22] Exit delays count from first edge clock enable high is registered.
// [RULE23] Write latency equals additive plus write CAS latency.
// [RULE24] Burst field 00, or 01 with A12 high, gives eight beats.
// [RULE25] Controller counts recovery for on-the-fly chop as full burst.
module dwsr_core
  import dwsr_pkg::*;
#(
  parameter int NBANK = 8,
  parameter int RW = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cke_pin,
  input wire logic [3:0] cmd_pin,
  input wire logic [2:0] ba_pin,
  input wire logic [15:0] addr_pin,
  input wire logic wdata_valid,
  output logic in_self_refresh,
  output logic dll_enabled,
  output logic dll_locked,
  output logic refresh_pulse,
  output logic wr_capture,
  output logic illegal_access
);
  typedef struct packed {
    logic [31:0] mode;
    logic [NBANK-1:0] open;
    dwsr_st_t st;
    logic [9:0] lock_cnt;
    logic [5:0] lat_cnt;
    logic wr_pend;
    logic [3:0] beats;
    logic [3:0] beat_cnt;
    logic [7:0] wbeats;
    logic ref_req;
    logic [31:0] dat;
    logic ack;
    logic sref;
    logic dll_en;
    logic dll_lk;
    logic ref_p;
    logic wcap;
    logic illg;
    logic held;
  } dwsr_state_t;

  dwsr_state_t s_q, s_d;
  logic [1:0] rst_sync_q;
  logic rst_n_int;
  dwsr_cmdbus_t sync1_q, sync2_q, sync3_q;
  logic [2:0] wv_q;
  logic row_we;
  logic [RW-1:0] row_rdata;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_q[1];

  // Pin synchronisers; stage one feeds only stage two
  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      wv_q <= 3'h0;
    end else begin
      sync1_q <= {cke_pin, cmd_pin, ba_pin, addr_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      wv_q <= {wv_q[1:0], wdata_valid};
    end
  end

  // Command is taken once the last two stages agree
  logic cmd_ok;
  logic cke_r;
  logic [3:0] cmd_r;
  assign cmd_ok = (sync2_q == sync3_q);
  assign cke_r = sync3_q.cke;
  assign cmd_r = (cmd_ok && !s_q.held) ? sync3_q.cmd : DWSR_CMD_NOP; // Acts once per change

  // Burst length decode, used for writes only
  function automatic logic [3:0] burst_beats(input logic [1:0] bl, input logic a12);
    logic [3:0] b;
    b = DWSR_BEATS_BL8;
    if (bl == DWSR_BL_FIXED4) begin
      b = DWSR_BEATS_BC4; // see [RULE3]
    end else if (bl == DWSR_BL_OTF && !a12) begin
      b = DWSR_BEATS_BC4; // see [RULE4]
    end else if (bl == DWSR_BL_OTF || bl == DWSR_BL_FIXED8) begin
      b = DWSR_BEATS_BL8; // see [RULE24]
    end
    return b;
  endfunction

  // Open-row store; written on activate
  assign row_we = (s_q.st == DWSR_ST_NORM) && cke_r && (cmd_r == DWSR_CMD_ACT);
  dwsr_bank_mem #(.DEPTH(NBANK), .AW(3), .DW(RW)) u_rows (
    .clk(mclk),
    .we(row_we),
    .waddr(sync3_q.ba),
    .wdata(sync3_q.addr[RW-1:0]),
    .raddr(sync3_q.ba),
    .rdata(row_rdata)
  );

  logic wb_req;
  logic [5:0] wl;
  assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wl = 6'(s_q.mode[DWSR_MODE_AL_LSB +: 4]) + 6'(s_q.mode[DWSR_MODE_CWL_LSB +: 4]);

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.ref_p = 1'b0;
    s_d.wcap = 1'b0;
    s_d.ack = 1'b0;
    s_d.held = cmd_ok; // Stays set until the pins move, so a held command is not repeated
    unique case (s_q.st)
      DWSR_ST_NORM: begin
        if (!cke_r && cmd_r == DWSR_CMD_REF && s_q.open == '0 && !s_q.wr_pend) begin
          s_d.st = DWSR_ST_SREF; // see [RULE10]
          s_d.sref = 1'b1;
          s_d.dll_en = 1'b0; // see [RULE11]
          s_d.dll_lk = 1'b0;
          s_d.ref_req = 1'b1; // see [RULE16]
        end else if (cke_r) begin
          unique case (cmd_r)
            DWSR_CMD_ACT: s_d.open[sync3_q.ba] = 1'b1;
            DWSR_CMD_PRE: begin
              if (sync3_q.addr[10]) begin
                s_d.open = '0; // see [RULE8]
              end else begin
                s_d.open[sync3_q.ba] = 1'b0; // see [RULE8] [RULE9]
              end
            end
            DWSR_CMD_WR, DWSR_CMD_RD: begin
              if (!s_q.open[sync3_q.ba]) begin
                s_d.illg = 1'b1; // see [RULE9]
              end else if (cmd_r == DWSR_CMD_WR) begin
                s_d.wr_pend = 1'b1;
                s_d.lat_cnt = wl; // see [RULE23]
                s_d.beats = burst_beats(s_q.mode[DWSR_MODE_BL_LSB +: 2], sync3_q.addr[12]);
                s_d.beat_cnt = 4'h0;
              end
            end
            default: ;
          endcase
        end
      end
      DWSR_ST_SREF: begin
        // Only clock enable is looked at here
        if (cke_r) begin
          s_d.st = DWSR_ST_RELK; // see [RULE15] [RULE22]
          s_d.sref = 1'b0;
          s_d.dll_en = 1'b1; // see [RULE11]
          s_d.lock_cnt = DWSR_DLL_LOCK_CYC;
        end
      end
      DWSR_ST_RELK: begin
        // DLL reset: count down before reporting lock
        if (s_q.lock_cnt == 10'h0) begin
          s_d.dll_lk = 1'b1;
          s_d.st = DWSR_ST_NORM;
        end else begin
          s_d.lock_cnt = s_q.lock_cnt - 10'h1;
        end
      end
      default: s_d.st = DWSR_ST_NORM;
    endcase
    // Internal refresh fired on the first cycle after entry
    if (s_q.ref_req) begin
      s_d.ref_req = 1'b0;
      s_d.ref_p = 1'b1; // see [RULE16]
    end
    // Write data capture after write latency
    if (s_q.wr_pend) begin
      if (s_q.lat_cnt != 6'h0) begin
        s_d.lat_cnt = s_q.lat_cnt - 6'h1;
      end else if (wv_q[2]) begin
        s_d.wcap = 1'b1; // see [RULE23]
        s_d.wbeats = s_q.wbeats + 8'h1;
        s_d.beat_cnt = s_q.beat_cnt + 4'h1;
        if (s_q.beat_cnt + 4'h1 == s_q.beats) begin
          s_d.wr_pend = 1'b0;
        end
      end
    end
    // Wishbone slave; one-cycle answer, ack dropped next cycle
    if (wb_req) begin
      s_d.ack = 1'b1;
      s_d.dat = 32'h0;
      unique case (wb_adr_i)
        DWSR_OFS_MODE: begin
          if (wb_we_i) begin
            for (int i = 0; i < 4; i++) begin
              if (wb_sel_i[i]) begin
                s_d.mode[i*8 +: 8] = wb_dat_i[i*8 +: 8];
              end
            end
          end
          s_d.dat = s_q.mode;
        end
        DWSR_OFS_STATUS: begin
          s_d.dat = {26'h0, s_q.illg, s_q.wr_pend, s_q.dll_lk, s_q.dll_en, s_q.st};
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[5]) begin
            s_d.illg = 1'b0;
          end
        end
        DWSR_OFS_BANKS: s_d.dat = 32'(s_q.open);
        DWSR_OFS_LAT: s_d.dat = {26'h0, wl};
        DWSR_OFS_WBEATS: s_d.dat = {24'h0, s_q.wbeats};
        default: s_d.dat = 32'h0;
      endcase
    end
    // A fresh illegal access wins over a software clear
    if (s_q.st == DWSR_ST_NORM && cke_r && (cmd_r == DWSR_CMD_WR || cmd_r == DWSR_CMD_RD)
        && !s_q.open[sync3_q.ba]) begin
      s_d.illg = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge mclk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q <= '0;
      s_q.mode <= DWSR_MODE_RST;
      s_q.st <= DWSR_ST_NORM;
      s_q.dll_en <= 1'b1;
      s_q.dll_lk <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign in_self_refresh = s_q.sref;
  assign dll_enabled = s_q.dll_en;
  assign dll_locked = s_q.dll_lk;
  assign refresh_pulse = s_q.ref_p;
  assign wr_capture = s_q.wcap;
  assign illegal_access = s_q.illg;
endmodule

// >>> testbench/dwsr_core_assertions.sv
// Checker for the DRAM command-timing core, bound to its ports.
// Assumes one clock, mclk, and the asynchronous reset reset_n.
`timescale 1ns/1ps
module dwsr_core_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cke_pin,
  input wire logic in_self_refresh,
  input wire logic dll_enabled,
  input wire logic dll_locked,
  input wire logic refresh_pulse
);
  logic [9:0] since_q;
  // Cycles since exit; saturates so a late lock change is still flagged
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) since_q <= 10'h3ff;
    else if (in_self_refresh) since_q <= 10'h0;
    else if (since_q != 10'h3ff) since_q <= since_q + 10'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_entry; $rose(in_self_refresh); endsequence
  sequence s_exit; $fell(in_self_refresh); endsequence
  ack_follows_a: assert property (s_take |=> wb_ack_o)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  entry_refresh_a: assert property (s_entry |-> ##[0:2] refresh_pulse)
    else $error("no refresh at entry");
  sref_dll_off_a: assert property (
    in_self_refresh && $past(in_self_refresh) |-> !dll_enabled)
    else $error("dll on in self refresh");
  exit_dll_reset_a: assert property (
    s_exit |-> ##[0:2] (dll_enabled && !dll_locked))
    else $error("dll not reset at exit");
  lock_time_a: assert property (
    $rose(dll_locked) |-> since_q >= 10'h1f9 && since_q <= 10'h208)
    else $error("dll lock time wrong");
  no_entry_a: assert property (
    (!in_self_refresh && cke_pin) [*6] |=> !in_self_refresh)
    else $error("entry with clock enable high");
  sref_hold_a: assert property (
    (in_self_refresh && !cke_pin) [*6] |=> in_self_refresh)
    else $error("left self refresh with cke low");
endmodule

// >>> testbench/dwsr_ctrl_model.sv
// Memory controller model driving the command pins and write beats.
// Assumes the bench calls its tasks; strobe and termination not pinned.
`timescale 1ns/1ps
module dwsr_ctrl_model
  import dwsr_pkg::*;
(
  input wire logic mclk,
  output logic cke_pin,
  output logic [3:0] cmd_pin,
  output logic [2:0] ba_pin,
  output logic [15:0] addr_pin,
  output logic wdata_valid
);
  initial begin
    cke_pin = 1'b1;
    cmd_pin = DWSR_CMD_NOP;
    ba_pin = 3'h0;
    addr_pin = 16'h0;
    wdata_valid = 1'b0;
  end
  // Hold 4 cycles for the 3-flop sync, then NOP fill
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [15:0] a, input logic k);
    @(posedge mclk);
    cmd_pin <= c;
    ba_pin <= b;
    addr_pin <= a;
    cke_pin <= k; // Low REF means entry, held low
    repeat (4) @(posedge mclk);
    cmd_pin <= DWSR_CMD_NOP;
    ba_pin <= ~b; // Idle lines toggle so stale values cannot pass
    addr_pin <= ~a;
    repeat (4) @(posedge mclk);
  endtask
  // One beat per cycle; strobe framing implied
  task automatic beats(input int n);
    repeat (n) begin
      @(posedge mclk);
      wdata_valid <= 1'b1;
    end
    @(posedge mclk);
    wdata_valid <= 1'b0;
  endtask
  // Recovery from full burst time for all chop kinds
  task automatic recover();
    repeat (12) @(posedge mclk);
  endtask
endmodule

// >>> testbench/dwsr_core_tb_top.sv
// Self-checking bench for the DRAM command-timing core.
// Assumes the controller model and checker files are compiled first.
`timescale 1ns/1ps
module dwsr_core_tb_top;
  import dwsr_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, wb_ack_o, cke_pin, wdata_valid, in_self_refresh;
  logic dll_enabled, dll_locked, refresh_pulse, wr_capture, illegal_access;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0, cmd_pin;
  logic [2:0] ba_pin;
  logic [15:0] addr_pin;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  int mismatches = 0, checked = 0, caps = 0, refs = 0;
  always #10 mclk = ~mclk;
  dwsr_core u_dwsr_core (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cke_pin(cke_pin),
    .cmd_pin(cmd_pin), .ba_pin(ba_pin), .addr_pin(addr_pin), .wdata_valid(wdata_valid),
    .in_self_refresh(in_self_refresh), .dll_enabled(dll_enabled),
    .dll_locked(dll_locked), .refresh_pulse(refresh_pulse), .wr_capture(wr_capture),
    .illegal_access(illegal_access));
  dwsr_ctrl_model u_dwsr_ctrl_model (.mclk(mclk), .cke_pin(cke_pin),
    .cmd_pin(cmd_pin), .ba_pin(ba_pin), .addr_pin(addr_pin), .wdata_valid(wdata_valid));
  // Pulse counters, compared as differences by the scenarios
  always @(posedge mclk) begin
    if (wr_capture === 1'b1) caps++;
    if (refresh_pulse === 1'b1) refs++;
  end
  task complete_run;
    if (mismatches == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Classic cycle: hold until ack sampled high, then release
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hf};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (i >= 20) begin
      mismatches++;
      complete_run;
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  // Bounded wait: 0 entry, 1 exit, 2 lock
  task wait_on(input int w, input int n);
    int i;
    i = 0;
    while (i < n && !(w == 0 ? in_self_refresh === 1'b1 :
           w == 1 ? in_self_refresh === 1'b0 : dll_locked === 1'b1)) begin
      @(posedge mclk);
      i++;
    end
    if (i >= n) begin
      mismatches++;
      complete_run;
    end
  endtask
  task t_regs;
    wb(1'b0, DWSR_OFS_MODE, 32'h0); chk(rd, DWSR_MODE_RST);
    wb(1'b0, DWSR_OFS_LAT, 32'h0); chk(rd, 32'h5);
    wb(1'b1, DWSR_OFS_MODE, 32'h0000_0521);
    wb(1'b0, DWSR_OFS_LAT, 32'h0); chk(rd, 32'h7);
    wb(1'b0, DWSR_OFS_STATUS, 32'h0); chk(rd, 32'h0c);
    wb(1'b1, 8'h14, 32'hffff_ffff);
    wb(1'b0, 8'h14, 32'h0); chk(rd, 32'h0);
  endtask
  // Burst length per mode field and A12; chopped bursts drop extra beats
  task t_burst;
    logic [1:0] bl [4] = '{DWSR_BL_FIXED4, DWSR_BL_OTF, DWSR_BL_OTF, DWSR_BL_FIXED8};
    logic a12 [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    int c0;
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, DWSR_OFS_MODE, {30'h140, bl[k]});
      u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h0, 16'h0, 1'b1);
      c0 = caps;
      u_dwsr_ctrl_model.issue(DWSR_CMD_WR, 3'h0, {3'h0, a12[k], 12'h0}, 1'b1);
      u_dwsr_ctrl_model.beats(8);
      repeat (8) @(posedge mclk);
      chk(caps - c0, (k < 2) ? 4 : 8);
      u_dwsr_ctrl_model.recover();
      u_dwsr_ctrl_model.issue(DWSR_CMD_PRE, 3'h0, 16'h0400, 1'b1);
    end
    // Beat counter holds all four bursts: 4 + 4 + 8 + 8
    wb(1'b0, DWSR_OFS_WBEATS, 32'h0); chk(rd, 32'h18);
  endtask
  task t_pre;
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h0, 16'h0, 1'b1);
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h3, 16'h0, 1'b1);
    wb(1'b0, DWSR_OFS_BANKS, 32'h0); chk(rd, 32'h09);
    u_dwsr_ctrl_model.issue(DWSR_CMD_PRE, 3'h5, 16'h0400, 1'b1);
    wb(1'b0, DWSR_OFS_BANKS, 32'h0); chk(rd, 32'h0);
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h1, 16'h0, 1'b1);
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h2, 16'h0, 1'b1);
    u_dwsr_ctrl_model.issue(DWSR_CMD_PRE, 3'h2, 16'h0, 1'b1);
    wb(1'b0, DWSR_OFS_BANKS, 32'h0); chk(rd, 32'h02);
    u_dwsr_ctrl_model.issue(DWSR_CMD_WR, 3'h2, 16'h0, 1'b1);
    chk(illegal_access, 1'b1);
    wb(1'b1, DWSR_OFS_STATUS, 32'h20);
    wb(1'b0, DWSR_OFS_STATUS, 32'h0); chk(rd[5], 1'b0);
    u_dwsr_ctrl_model.issue(DWSR_CMD_PRE, 3'h0, 16'h0400, 1'b1);
  endtask
  // Refused entry with an open bank, then entry, residency and exit
  task t_sref;
    int r0;
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h0, 16'h0, 1'b1);
    u_dwsr_ctrl_model.issue(DWSR_CMD_REF, 3'h0, 16'h0, 1'b0);
    chk(in_self_refresh, 1'b0);
    u_dwsr_ctrl_model.issue(DWSR_CMD_PRE, 3'h0, 16'h0400, 1'b1);
    r0 = refs;
    u_dwsr_ctrl_model.issue(DWSR_CMD_REF, 3'h0, 16'h0, 1'b0);
    wait_on(0, 20);
    chk(dll_enabled, 1'b0);
    chk(refs > r0, 1'b1);
    u_dwsr_ctrl_model.issue(DWSR_CMD_ACT, 3'h1, 16'h0, 1'b0);
    wb(1'b0, DWSR_OFS_BANKS, 32'h0); chk(rd, 32'h0);
    repeat (10) @(posedge mclk); // Residency, clock kept
    u_dwsr_ctrl_model.issue(DWSR_CMD_NOP, 3'h0, 16'h0, 1'b1);
    wait_on(1, 20);
    chk({dll_enabled, dll_locked}, 2'b10);
    wait_on(2, 700); // No writes before lock
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs;
    t_burst;
    t_pre;
    t_sref;
    complete_run;
  end
endmodule
bind dwsr_core dwsr_core_assertions u_dwsr_core_assertions (.mclk(mclk),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .cke_pin(cke_pin), .in_self_refresh(in_self_refresh), .dll_enabled(dll_enabled),
  .dll_locked(dll_locked), .refresh_pulse(refresh_pulse));
